// ### dv/temperature_peak_hold_settings_test.sv
// Self-checking bench for the temperature peak hold block
`timescale 1ns/1ps
module temperature_peak_hold_settings_test;
  logic        mclk, reset_n, run, sampleValid, localSwitchMode, swLive4mA, extClearContact;
  logic        regWrite, regRead;
  logic [15:0] temp, rawTemp, holdTemp, analogCode;
  logic [6:0]  swEmissivity;
  logic [3:0]  swResponse;
  logic [1:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  int          badCount, samplesChecked, cyc;

  tph_sensor_model sen_u (.mclk(mclk), .reset_n(reset_n), .run(run), .tempIn(temp),
    .sampleValid(sampleValid), .rawTemp(rawTemp));
  tph_peak_hold dut_u (.mclk(mclk), .reset_n(reset_n), .sampleValid(sampleValid),
    .rawTemp(rawTemp), .localSwitchMode(localSwitchMode), .swEmissivity(swEmissivity),
    .swResponse(swResponse), .swLive4mA(swLive4mA), .extClearContact(extClearContact),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .holdTemp(holdTemp), .analogCode(analogCode));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic endSim();
    $display("Checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      badCount++;
      endSim();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      badCount++;
    end
  endtask

  task automatic chkNear(input string n, input int e, input logic [15:0] g);
    samplesChecked++;
    if ($isunknown(g) || int'(g) < e - 64 || int'(g) > e + 64) begin
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
      badCount++;
    end
  endtask

  task automatic rst();
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rdv = regRdata;
  endtask

  task automatic feed(input logic [15:0] t);
    temp <= t;
    repeat (6) @(posedge mclk);
  endtask

  task automatic testReset();
    rd(tph_pkg::REG_CTRL);
    chk("ctrl mode", 32'h0000_0000, {28'h000_0000, rdv[3:0]});
    rd(tph_pkg::REG_PARAM);
    chk("param emi", {25'h000_0000, tph_pkg::EMI_RESET}, {25'h000_0000, rdv[6:0]});
    $display("[DONE] reset values");
  endtask

  task automatic testResponse();
    logic [3:0] rc [8];
    logic [3:0] sh [8];
    int         n, lim, cnt;
    rc = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hA, 4'h3};
    sh = '{tph_pkg::SH_NONE, tph_pkg::SH_0P5, tph_pkg::SH_1, tph_pkg::SH_2, tph_pkg::SH_5,
           tph_pkg::SH_10, tph_pkg::SH_30, tph_pkg::SH_NONE};
    for (int i = 0; i < 8; i++) begin
      swResponse <= rc[i];
      temp       <= 16'h0000;
      rst();
      n   = (sh[i] == 4'h0) ? 1 : int'($ceil($ln(0.1) / $ln(1.0 - 1.0 / (2.0 ** sh[i]))));
      lim = n * 11 / 10 + 6;
      cnt = 0;
      temp <= 16'h0FA0;
      while (!(holdTemp >= 16'h0E10) && cnt < lim) begin
        @(posedge mclk);
        cnt++;
      end
      samplesChecked++;
      if (cnt < n * 9 / 10 || cnt >= lim) begin
        $display("[FAIL] response cycles for %h expected %0d seen %0d", rc[i], n, cnt);
        badCount++;
      end
    end
    swResponse <= 4'h0;
    rst();
    $display("[DONE] response time");
  endtask

  task automatic testEmissivity();
    swEmissivity <= 7'h32;
    feed(16'h0190);
    chk("emi 50", 32'h0000_0320, {16'h0000, holdTemp});
    swEmissivity <= 7'h0A;
    feed(16'h0190);
    chk("emi clamp", 32'h0000_07D0, {16'h0000, holdTemp});
    localSwitchMode <= 1'b0;
    wr(tph_pkg::REG_PARAM, 32'h0000_0050);
    feed(16'h0190);
    chk("remote emi", 32'h0000_01F4, {16'h0000, holdTemp});
    wr(tph_pkg::REG_PARAM, 32'h0000_000A);
    feed(16'h0190);
    chk("remote emi refused", 32'h0000_01F4, {16'h0000, holdTemp});
    localSwitchMode <= 1'b1;
    swEmissivity    <= 7'h64;
    feed(16'h0190);
    chk("momentary", 32'h0000_0190, {16'h0000, holdTemp});
    $display("[DONE] emissivity");
  endtask

  task automatic testExtHold();
    wr(tph_pkg::REG_CTRL, 32'h0000_0004);
    feed(16'h012C);
    feed(16'h02BC);
    feed(16'h0190);
    chk("max held", 32'h0000_02BC, {16'h0000, holdTemp});
    extClearContact <= 1'b1;
    feed(16'h00C8);
    extClearContact <= 1'b0;
    feed(16'h00C8);
    chk("contact clear", 32'h0000_00C8, {16'h0000, holdTemp});
    feed(16'h0064);
    wr(tph_pkg::REG_CTRL, 32'h0000_000C);
    feed(16'h0064);
    chk("host clear", 32'h0000_0064, {16'h0000, holdTemp});
    feed(16'h01F4);
    wr(tph_pkg::REG_CTRL, 32'h0000_000D);
    feed(16'h01F4);
    feed(16'h00C8);
    feed(16'h0258);
    chk("min held", 32'h0000_00C8, {16'h0000, holdTemp});
    $display("[DONE] external clear");
  endtask

  task automatic testTimed();
    wr(tph_pkg::REG_CTRL, 32'h0000_0004);
    wr(tph_pkg::REG_CTRL, 32'h0000_0002);
    rd(tph_pkg::REG_CTRL);
    chk("clear time 0 refused", 32'h0000_0012, {16'h0000, rdv[15:0]});
    wr(tph_pkg::REG_CTRL, 32'h0000_0642);
    rd(tph_pkg::REG_CTRL);
    chk("clear time taken", 32'h0000_0642, {16'h0000, rdv[15:0]});
    $display("[DONE] timed clear");
  endtask

  task automatic testAuto();
    wr(tph_pkg::REG_LIMITS, 32'h0BB8_03E8);
    wr(tph_pkg::REG_CTRL, 32'h0000_0006);
    feed(16'h0384);
    feed(16'h05DC);
    feed(16'h04B0);
    feed(16'h0384);
    chk("auto max kept", 32'h0000_05DC, {16'h0000, holdTemp});
    feed(16'h041A);
    chk("auto max cleared", 32'h0000_041A, {16'h0000, holdTemp});
    wr(tph_pkg::REG_CTRL, 32'h0000_0007);
    feed(16'h0DAC);
    feed(16'h07D0);
    feed(16'h09C4);
    feed(16'h0DAC);
    chk("auto min kept", 32'h0000_07D0, {16'h0000, holdTemp});
    feed(16'h0B54);
    chk("auto min cleared", 32'h0000_0B54, {16'h0000, holdTemp});
    $display("[DONE] auto clear");
  endtask

  task automatic testSubrange();
    wr(tph_pkg::REG_CTRL, 32'h0000_0000);
    feed(16'h07D0);
    chkNear("analog 0-20", 32767, analogCode);
    wr(tph_pkg::REG_LIMITS, 32'h044C_03E8);
    feed(16'h07D0);
    chkNear("narrow refused", 32767, analogCode);
    swLive4mA <= 1'b1;
    feed(16'h07D0);
    chkNear("analog 4-20", 39321, analogCode);
    $display("[DONE] subrange");
  endtask

  initial begin
    reset_n = 1'b0;
    run = 1'b1;
    temp = 16'h0000;
    localSwitchMode = 1'b1;
    swEmissivity = 7'h64;
    swResponse = 4'h0;
    swLive4mA = 1'b0;
    extClearContact = 1'b0;
    regAddr = 2'h0;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    badCount = 0;
    samplesChecked = 0;
    cyc = 0;
    rst();
    testReset();
    testResponse();
    testEmissivity();
    testExtHold();
    testTimed();
    testAuto();
    testSubrange();
    endSim();
  end
endmodule // temperature_peak_hold_settings_test

// ### dv/tph_sensor_model.sv
// Sensor model that hands one temperature sample to the block per clock
`timescale 1ns/1ps
module tph_sensor_model (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Control from the bench
  input  wire logic                       run,
  input  wire logic [tph_pkg::TEMP_W-1:0] tempIn,
  // Measurement
  output logic                            sampleValid,
  output logic      [tph_pkg::TEMP_W-1:0] rawTemp
);
  // Data line toggles when no sample is offered
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sampleValid <= 1'b0;
      rawTemp     <= 16'h0000;
    end else if (run) begin
      sampleValid <= 1'b1;
      rawTemp     <= tempIn;
    end else begin
      sampleValid <= 1'b0;
      rawTemp     <= ~rawTemp;
    end
  end
endmodule // tph_sensor_model

// ### logic/tph_peak_hold.sv
// Temperature peak hold with settings, smoothing, hold and subrange mapping
`timescale 1ns/1ps
module tph_peak_hold (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Measurement
  input  wire logic                       sampleValid,
  input  wire logic [tph_pkg::TEMP_W-1:0] rawTemp,
  // Local switches
  input  wire logic                       localSwitchMode,
  input  wire logic [6:0]                 swEmissivity,
  input  wire logic [3:0]                 swResponse,
  input  wire logic                       swLive4mA,
  input  wire logic                       extClearContact,
  // Register port
  input  wire logic [1:0]                 regAddr,
  input  wire logic [31:0]                regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [31:0]                regRdata,
  // Results
  output logic      [tph_pkg::TEMP_W-1:0] holdTemp,
  output logic      [tph_pkg::OUT_W-1:0]  analogCode
);
  // Remote parameters
  logic [6:0]  remEmi_ff;
  logic [3:0]  remResp_ff;
  logic        remLive_ff;
  logic        minMode_ff;
  logic [1:0]  clrMode_ff;
  logic [11:0] clrTime_ff;
  logic [15:0] limLo_ff;
  logic [15:0] limHi_ff;
  logic        limLoSet_ff;
  logic        limHiSet_ff;
  logic        hostClear;
  // Register writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      remEmi_ff   <= tph_pkg::EMI_RESET;
      remResp_ff  <= 4'h0;
      remLive_ff  <= 1'b0;
      minMode_ff  <= 1'b0;
      clrMode_ff  <= tph_pkg::CLR_OFF;
      clrTime_ff  <= tph_pkg::CLR_MIN;
      limLo_ff    <= tph_pkg::FULL_LO;
      limHi_ff    <= tph_pkg::FULL_HI;
      limLoSet_ff <= 1'b0;
      limHiSet_ff <= 1'b0;
    end else if (regWrite) begin
      unique case (regAddr)
        tph_pkg::REG_CTRL: begin
          minMode_ff <= regWdata[0];
          clrMode_ff <= regWdata[2:1];
          if (regWdata[15:4] >= tph_pkg::CLR_MIN && regWdata[15:4] <= tph_pkg::CLR_MAX) begin
            clrTime_ff <= regWdata[15:4];
          end
        end
        tph_pkg::REG_LIMITS: begin
          // Subrange kept only when it is wide enough
          if (17'(regWdata[31:16]) >= 17'(regWdata[15:0]) + 17'(tph_pkg::MIN_SPAN)) begin
            limLo_ff    <= regWdata[15:0];
            limHi_ff    <= regWdata[31:16];
            limLoSet_ff <= regWdata[15:0] != tph_pkg::FULL_LO;
            limHiSet_ff <= regWdata[31:16] != tph_pkg::FULL_HI;
          end
        end
        tph_pkg::REG_PARAM: begin
          if (!localSwitchMode) begin
            if (regWdata[6:0] >= tph_pkg::EMI_MIN && regWdata[6:0] <= tph_pkg::EMI_MAX) begin
              remEmi_ff <= regWdata[6:0];
            end
            remResp_ff <= regWdata[11:8];
            remLive_ff <= regWdata[12];
          end
        end
        default: begin
        end
      endcase
    end
  end
  assign hostClear = regWrite && regAddr == tph_pkg::REG_CTRL && regWdata[3];
  // Effective settings
  logic [6:0] emi;
  logic [3:0] resp;
  logic       live;
  logic [3:0] shift;
  always_comb begin
    if (localSwitchMode) begin
      emi  = (swEmissivity < tph_pkg::EMI_MIN) ? tph_pkg::EMI_MIN :
             (swEmissivity > tph_pkg::EMI_MAX) ? tph_pkg::EMI_MAX : swEmissivity;
      resp = swResponse;
      live = swLive4mA;
    end else begin
      emi  = remEmi_ff;
      resp = remResp_ff;
      live = remLive_ff;
    end
    unique case (resp)
      4'b0001: shift = tph_pkg::SH_0P5;
      4'b0010: shift = tph_pkg::SH_1;
      4'b0100: shift = tph_pkg::SH_2;
      4'b1000: shift = tph_pkg::SH_5;
      4'b1001: shift = tph_pkg::SH_10;
      4'b1010: shift = tph_pkg::SH_30;
      default: shift = tph_pkg::SH_NONE;
    endcase
  end
  // Emissivity correction: temp * 100 / emi, saturated
  logic [31:0] corrWide;
  logic [15:0] corrTemp;
  always_comb begin
    corrWide = (32'(rawTemp) * 32'd100) / 32'(emi);
    corrTemp = (corrWide > 32'h0000_FFFF) ? 16'hFFFF : corrWide[15:0];
  end
  // First order smoothing, 90 % step settles in about 2.3 * 2^shift samples
  logic [31:0] filt_ff;
  logic [31:0] nxt_filt;
  logic        primed_ff;
  always_comb begin
    if (!primed_ff || shift == tph_pkg::SH_NONE) begin
      nxt_filt = {corrTemp, 16'h0000};
    end else begin
      nxt_filt = filt_ff + ({corrTemp, 16'h0000} >> shift) - (filt_ff >> shift);
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      filt_ff   <= 32'h0000_0000;
      primed_ff <= 1'b0;
    end else if (sampleValid) begin
      filt_ff   <= nxt_filt;
      primed_ff <= 1'b1;
    end
  end
  logic [15:0] smooth;
  assign smooth = filt_ff[31:16];
  // Clear time base
  logic [19:0] tickCnt_ff;
  logic [11:0] unitCnt_ff;
  logic        intervalEnd;
  assign intervalEnd = tickCnt_ff == 20'(tph_pkg::TICK_CYC * tph_pkg::CLR_UNIT_TICKS - 1)
                       && unitCnt_ff == clrTime_ff - 12'h001;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_ff <= 20'h0_0000;
      unitCnt_ff <= 12'h000;
    end else if (clrMode_ff != tph_pkg::CLR_TIME) begin
      tickCnt_ff <= 20'h0_0000;
      unitCnt_ff <= 12'h000;
    end else if (tickCnt_ff == 20'(tph_pkg::TICK_CYC * tph_pkg::CLR_UNIT_TICKS - 1)) begin
      tickCnt_ff <= 20'h0_0000;
      unitCnt_ff <= intervalEnd ? 12'h000 : unitCnt_ff + 12'h001;
    end else begin
      tickCnt_ff <= tickCnt_ff + 20'h0_0001;
    end
  end
  // Auto clear thresholds: margin is max(1 %, 2 C)
  logic [15:0] loRef;
  logic [15:0] hiRef;
  logic [15:0] loMarg;
  logic [15:0] hiMarg;
  logic        autoClr;
  always_comb begin
    loRef  = limLoSet_ff ? limLo_ff : tph_pkg::FULL_LO;
    hiRef  = limHiSet_ff ? limHi_ff : tph_pkg::FULL_HI;
    loMarg = (loRef / 16'd100 > tph_pkg::MARGIN_MIN) ? loRef / 16'd100 : tph_pkg::MARGIN_MIN;
    hiMarg = (hiRef / 16'd100 > tph_pkg::MARGIN_MIN) ? hiRef / 16'd100 : tph_pkg::MARGIN_MIN;
    if (!minMode_ff) begin
      autoClr = limLoSet_ff ? (17'(smooth) > 17'(loRef) + 17'(loMarg))
                            : (smooth > loRef);
    end else begin
      autoClr = limHiSet_ff ? (17'(smooth) + 17'(hiMarg) < 17'(hiRef))
                            : (smooth < hiRef);
    end
  end
  // Auto clear fires once as the threshold is crossed
  logic autoPrev_ff;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      autoPrev_ff <= 1'b0;
    end else if (sampleValid) begin
      autoPrev_ff <= autoClr;
    end
  end
  // Hold memories
  logic [15:0] mem_ff [2];
  logic        clrPend_ff [2];
  logic        active_ff;
  logic        extClr;
  assign extClr = hostClear || extClearContact;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 1'b0;
    end else if (clrMode_ff == tph_pkg::CLR_TIME && intervalEnd) begin
      active_ff <= ~active_ff;
    end
  end
  for (genvar i = 0; i < 2; i++) begin : gMem
    logic clrNow;
    logic better;
    assign clrNow = (clrMode_ff == tph_pkg::CLR_OFF)
                    || (clrMode_ff == tph_pkg::CLR_TIME && intervalEnd && active_ff == 1'(i))
                    || (i == 0 && clrMode_ff == tph_pkg::CLR_EXT && extClr)
                    || (i == 0 && clrMode_ff == tph_pkg::CLR_AUTO && autoClr && !autoPrev_ff
                        && sampleValid);
    assign better = minMode_ff ? (smooth < mem_ff[i]) : (smooth > mem_ff[i]);
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        mem_ff[i]     <= 16'h0000;
        clrPend_ff[i] <= 1'b1;
      end else if (clrNow) begin
        clrPend_ff[i] <= 1'b1;
      end else if (sampleValid) begin
        if (clrPend_ff[i] || better) begin
          mem_ff[i] <= smooth;
        end
        clrPend_ff[i] <= 1'b0;
      end
    end
  end
  // Output selection
  logic [15:0] shown;
  always_comb begin
    unique case (clrMode_ff)
      tph_pkg::CLR_OFF: shown = smooth;
      tph_pkg::CLR_TIME: begin
        if (clrPend_ff[0]) begin
          shown = mem_ff[1];
        end else if (clrPend_ff[1]) begin
          shown = mem_ff[0];
        end else begin
          shown = (minMode_ff ^ (mem_ff[0] > mem_ff[1])) ? mem_ff[0] : mem_ff[1];
        end
      end
      default: shown = clrPend_ff[0] ? smooth : mem_ff[0];
    endcase
  end
  // Subrange to analog code; live zero uses 4 of 20 mA
  logic [15:0] clampT;
  logic [31:0] scaled;
  logic [15:0] zeroCode;
  logic [31:0] spanCode;
  always_comb begin
    clampT   = (shown < limLo_ff) ? limLo_ff : (shown > limHi_ff) ? limHi_ff : shown;
    zeroCode = live ? 16'h3333 : 16'h0000;
    spanCode = 32'(16'hFFFF - zeroCode);
    scaled   = (32'(clampT - limLo_ff) * spanCode) / 32'(limHi_ff - limLo_ff);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      holdTemp   <= 16'h0000;
      analogCode <= 16'h0000;
    end else begin
      holdTemp   <= shown;
      analogCode <= zeroCode + scaled[15:0];
    end
  end
  // Register read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRead) begin
      unique case (regAddr)
        tph_pkg::REG_CTRL:   regRdata <= {16'h0000, clrTime_ff, 1'b0, clrMode_ff, minMode_ff};
        tph_pkg::REG_LIMITS: regRdata <= {limHi_ff, limLo_ff};
        tph_pkg::REG_STATUS: regRdata <= {smooth, shown};
        tph_pkg::REG_PARAM:  regRdata <= {15'h0000, localSwitchMode, 3'h0, live, resp, 1'b0, emi};
        default:             regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
  // Checks
  a_emi_range: assert property (@(posedge mclk) disable iff (!reset_n)
    emi >= tph_pkg::EMI_MIN && emi <= tph_pkg::EMI_MAX) else $error("emissivity out of range");
  a_resp_ten: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b1001 |-> shift == tph_pkg::SH_10) else $error("10 s select wrong");
  a_resp_thirty: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b1010 |-> shift == tph_pkg::SH_30) else $error("30 s select wrong");
  a_no_smooth: assert property (@(posedge mclk) disable iff (!reset_n)
    sampleValid && shift == tph_pkg::SH_NONE |=> smooth == $past(corrTemp))
    else $error("unsmoothed path wrong");
  a_off_live: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_OFF |=> holdTemp == $past(smooth)) else $error("off mode held");
  a_remote_local: assert property (@(posedge mclk) disable iff (!reset_n)
    localSwitchMode |-> resp == swResponse) else $error("switch ignored offline");
  a_max_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_EXT && !minMode_ff && !clrPend_ff[0] && !extClr
    && $stable(clrMode_ff) |=> mem_ff[0] >= $past(mem_ff[0])) else $error("max dropped");
  a_ext_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_EXT && extClr |=> clrPend_ff[0]) else $error("clear lost");
  a_reload: assert property (@(posedge mclk) disable iff (!reset_n)
    clrPend_ff[0] && sampleValid && !gMem[0].clrNow |=> mem_ff[0] == $past(smooth))
    else $error("reload wrong");
  a_resp_half: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b0001 |-> shift == tph_pkg::SH_0P5)
    else $error("0.5 s select wrong");
  a_resp_one: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b0010 |-> shift == tph_pkg::SH_1)
    else $error("1 s select wrong");
  a_resp_two: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b0100 |-> shift == tph_pkg::SH_2)
    else $error("2 s select wrong");
  a_resp_five: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b1000 |-> shift == tph_pkg::SH_5)
    else $error("5 s select wrong");
  a_resp_other: assert property (@(posedge mclk) disable iff (!reset_n)
    resp == 4'b0011 |-> shift == tph_pkg::SH_NONE)
    else $error("odd switch combination smoothed");
  a_local_emi: assert property (@(posedge mclk) disable iff (!reset_n)
    localSwitchMode && swEmissivity >= tph_pkg::EMI_MIN && swEmissivity <= tph_pkg::EMI_MAX
    |-> emi == swEmissivity) else $error("switch emissivity not used");
  a_remote_cfg: assert property (@(posedge mclk) disable iff (!reset_n)
    !localSwitchMode |-> resp == remResp_ff && emi == remEmi_ff)
    else $error("switches used in remote mode");
  a_off_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_OFF |=> clrPend_ff[0] && clrPend_ff[1])
    else $error("hold active while off");
  a_auto_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_AUTO && sampleValid && autoClr && !autoPrev_ff |=> clrPend_ff[0])
    else $error("auto clear missed");
  a_time_toggle: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_TIME && intervalEnd |=> active_ff != $past(active_ff))
    else $error("memories not alternated");
  a_min_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    clrMode_ff == tph_pkg::CLR_EXT && minMode_ff && !clrPend_ff[0] && !extClr
    && $stable(clrMode_ff) && $stable(minMode_ff) |=> mem_ff[0] <= $past(mem_ff[0]))
    else $error("min raised");
  a_span_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    17'(limHi_ff) >= 17'(limLo_ff) + 17'(tph_pkg::MIN_SPAN))
    else $error("subrange too narrow");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    !regRead |=> regRdata == 32'h0000_0000)
    else $error("read data without read");
  a_hold_shown: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> holdTemp == $past(shown))
    else $error("held value not shown");
  a_analog_low: assert property (@(posedge mclk) disable iff (!reset_n)
    shown <= limLo_ff |=> analogCode == $past(zeroCode))
    else $error("subrange bottom not zero");
  c_time_swap: cover property (@(posedge mclk) clrMode_ff == tph_pkg::CLR_TIME && intervalEnd);
  c_live_zero: cover property (@(posedge mclk) live && shown > limLo_ff);
  c_auto_clr: cover property (@(posedge mclk) clrMode_ff == tph_pkg::CLR_AUTO && autoClr);
  c_ext_clr: cover property (@(posedge mclk) clrMode_ff == tph_pkg::CLR_EXT && extClr);
endmodule // tph_peak_hold

// ### logic/tph_pkg.sv
// Constants and types of the temperature peak hold block
// Notes on behaviour
// - Local emissivity accepted only from 20 to 100 percent and applied to temperature.
// - Single response switch on selects 0.5, 1, 2 or 5 s response.
// - Switches 0.5 s and 5 s both on select 10 s response.
// - Switches 1 s and 5 s both on select 30 s response.
// - All response switches off means no added smoothing.
// - Response time is when output reaches 90 percent of a step.
// - Local switches used for emissivity and response only in local mode.
// - Maximum storage holds highest value, minimum storage holds lowest value.
// - Clear mode off disables hold and outputs momentary values.
// - Clear time 0.01 to 25 s runs double memory, clearing each interval.
// - Two memories cleared alternately; the other keeps the extreme meanwhile.
// - External mode uses one memory cleared by host command or contact.
// - After an external clear a new held value builds from later samples.
// - Auto mode clears maximum when temperature exceeds low limit by 1%/2 C.
// - Auto mode without low limit clears maximum above full range bottom.
// - Auto mode clears minimum below upper limit by 1%/2 C, else full top.
// - Hold storage works on the smoothed value.
// - Subrange, at least 51 C wide, maps to full analog output span.
// - In remote mode switches are ignored; serial parameters are used.
// - After reset maximum storage is selected and clear time is off.
package tph_pkg;
  localparam int TEMP_W = 16;
  localparam int OUT_W = 16;
  localparam logic [6:0] EMI_MIN = 7'd20;
  localparam logic [6:0] EMI_MAX = 7'd100;
  localparam logic [6:0] EMI_RESET = 7'd100;
  // Temperature in units of 0.1 C
  localparam logic [15:0] MIN_SPAN = 16'h01FE;
  localparam logic [15:0] MARGIN_MIN = 16'h0014;
  localparam logic [15:0] FULL_LO = 16'h0000;
  localparam logic [15:0] FULL_HI = 16'h0FA0;
  // Measurement tick period
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // Clear time in 10 ms units, 1 to 2500
  localparam logic [11:0] CLR_MIN = 12'h001;
  localparam logic [11:0] CLR_MAX = 12'h9C4;
  localparam int CLR_UNIT_TICKS = 10;
  // Smoothing shift per response time: 90 % step in about t / 1 ms samples, except 30 s, which settles in about 18800 samples
  localparam logic [3:0] SH_0P5 = 4'h8;
  localparam logic [3:0] SH_1 = 4'h9;
  localparam logic [3:0] SH_2 = 4'hA;
  localparam logic [3:0] SH_5 = 4'hB;
  localparam logic [3:0] SH_10 = 4'hC;
  localparam logic [3:0] SH_30 = 4'hD;
  localparam logic [3:0] SH_NONE = 4'h0;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_LIMITS = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_PARAM = 2'h3;
  typedef enum logic [1:0] {
    CLR_OFF  = 2'b00,
    CLR_TIME = 2'b01,
    CLR_EXT  = 2'b10,
    CLR_AUTO = 2'b11
  } tph_clr_t;
endpackage
